// ===== cscs_pkg.sv
package cscs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OSC = 8'h04;
  localparam logic [7:0] ADDR_GPO = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // ctrl fields
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_PCLK_DIS_BIT = 1;
  localparam int CTRL_MODE12_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  // oscillator frequency field
  localparam int OSC_LSB = 1;
  localparam logic [1:0] OSC_CODE_DEFAULT = 2'h1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int LOSS_TIME_NS = 1000;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SETTLE_TIME_NS = 200;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CNT_W = 8;
  localparam int PIX_W = 14;

  typedef enum logic [1:0] {CSCS_SRC_OSC, CSCS_SRC_SETTLE, CSCS_SRC_PCLK} cscs_src_type;

  typedef struct packed {
    logic mode12;
    logic edge_rise;
    logic pclk_dis;
    logic [1:0] osc_code;
  } cscs_cfg_type;
endpackage

// ===== cscs_edge_detect.sv
`timescale 1ns/10ps
module cscs_edge_detect
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampled clock-like input
  input wire logic sig_in,
  // detected edges
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } cscs_ed_type;

  cscs_ed_type st_r;
  cscs_ed_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = sig_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // edges judged on stages two and three only
  assign rise = st_r.s2 & ~st_r.s3;
  assign fall = ~st_r.s2 & st_r.s3;
endmodule // cscs_edge_detect

// ===== cscs_clock_select.sv
`timescale 1ns/10ps
module cscs_clock_select
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // imager side
  input wire logic power_down_n,
  input wire logic mode_strap_ext,
  input wire logic pclk_in,
  input wire logic [13:0] pixel_in,
  // external oscillator on gpio three, reference on gpio two
  input wire logic gpio_three_osc_in,
  output logic gpio_two_ref_out,
  // remote gpio values from back channel, self test oscillator code
  input wire logic [3:0] remote_gpio,
  input wire logic self_test,
  input wire logic [1:0] remote_osc_code,
  // general outputs
  output logic [3:0] gpo_out,
  output logic [3:0] gpo_oe,
  // serial side
  output logic [13:0] frame_data,
  output logic frame_valid,
  output logic serial_idle_high,
  output logic link_on_osc
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic have_aw;
    logic have_w;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    cscs_pkg::cscs_cfg_type cfg;
    logic [3:0] gpo_local;
    logic [3:0] gpo_sel_remote;
    logic strap_ext;
    logic strap_done;
    cscs_pkg::cscs_src_type src;
    logic [cscs_pkg::CNT_W-1:0] loss_cnt;
    logic [cscs_pkg::CNT_W-1:0] settle_cnt;
    logic [13:0] pix;
    logic [1:0][13:0] pix_dly;
    logic pix_ok;
    logic [1:0] phase;
    logic [13:0] frame_data;
    logic frame_valid;
    logic idle_high;
    logic ref_div;
    logic [3:0] gpo_out;
    logic [3:0] gpo_oe;
    logic on_osc;
  } cscs_state_type;

  cscs_state_type st_r;
  cscs_state_type st_nxt;
  logic pclk_rise;
  logic pclk_fall;
  logic osc_rise;

  cscs_edge_detect u_pclk_edge
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(pclk_in),
    .rise(pclk_rise),
    .fall(pclk_fall)
  );

  cscs_edge_detect u_osc_edge
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .sig_in(gpio_three_osc_in),
    .rise(osc_rise),
    .fall()
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[i*8 +: 8] = dat[i*8 +: 8];
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == cscs_pkg::ADDR_CTRL || a == cscs_pkg::ADDR_OSC || a == cscs_pkg::ADDR_GPO ||
      a == cscs_pkg::ADDR_STATUS;
  endfunction

  logic cap_edge;
  logic [31:0] wr_val;
  logic [31:0] cur_val;
  logic ext_mode;

  always_comb
  begin
    st_nxt = st_r;
    cur_val = '0;
    wr_val = '0;
    ext_mode = st_r.strap_ext;
    // strap caught once after reset release
    if (!st_r.strap_done)
    begin
      st_nxt.strap_ext = mode_strap_ext;
      st_nxt.strap_done = 1'b1;
    end
    // write channel: address and data in either order
    if (s_axi_awvalid && st_r.awready)
    begin
      st_nxt.awaddr = s_axi_awaddr;
      st_nxt.have_aw = 1'b1;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready)
    begin
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
      st_nxt.have_w = 1'b1;
      st_nxt.wready = 1'b0;
    end
    if (st_r.have_aw && st_r.have_w && !st_r.bvalid)
    begin
      st_nxt.have_aw = 1'b0;
      st_nxt.have_w = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.awaddr) ? cscs_pkg::RESP_OKAY : cscs_pkg::RESP_SLVERR;
      case (st_r.awaddr)
        cscs_pkg::ADDR_CTRL:
        begin
          cur_val = 32'h0;
          cur_val[cscs_pkg::CTRL_EDGE_BIT] = st_r.cfg.edge_rise;
          cur_val[cscs_pkg::CTRL_PCLK_DIS_BIT] = st_r.cfg.pclk_dis;
          cur_val[cscs_pkg::CTRL_MODE12_BIT] = st_r.cfg.mode12;
          wr_val = merge(cur_val, st_r.wdata, st_r.wstrb);
          st_nxt.cfg.edge_rise = wr_val[cscs_pkg::CTRL_EDGE_BIT];
          st_nxt.cfg.pclk_dis = wr_val[cscs_pkg::CTRL_PCLK_DIS_BIT];
          st_nxt.cfg.mode12 = wr_val[cscs_pkg::CTRL_MODE12_BIT];
        end
        cscs_pkg::ADDR_OSC:
        begin
          // software writes ignored in self test, field owned by remote
          if (!self_test)
          begin
            wr_val = merge(32'h0, st_r.wdata, st_r.wstrb);
            if (st_r.wstrb[0])
              st_nxt.cfg.osc_code = wr_val[cscs_pkg::OSC_LSB +: 2];
          end
        end
        cscs_pkg::ADDR_GPO:
        begin
          wr_val = merge({24'h0, st_r.gpo_sel_remote, st_r.gpo_local}, st_r.wdata, st_r.wstrb);
          st_nxt.gpo_local = wr_val[3:0];
          st_nxt.gpo_sel_remote = wr_val[7:4];
        end
        default:
        begin
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end
    if (self_test)
      st_nxt.cfg.osc_code = remote_osc_code;
    // read channel
    if (s_axi_arvalid && st_r.arready)
    begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = mapped(s_axi_araddr) ? cscs_pkg::RESP_OKAY : cscs_pkg::RESP_SLVERR;
      st_nxt.rdata = 32'h0;
      case (s_axi_araddr)
        cscs_pkg::ADDR_CTRL:
        begin
          st_nxt.rdata[cscs_pkg::CTRL_EDGE_BIT] = st_r.cfg.edge_rise;
          st_nxt.rdata[cscs_pkg::CTRL_PCLK_DIS_BIT] = st_r.cfg.pclk_dis;
          st_nxt.rdata[cscs_pkg::CTRL_MODE12_BIT] = st_r.cfg.mode12;
        end
        cscs_pkg::ADDR_OSC:
          st_nxt.rdata[cscs_pkg::OSC_LSB +: 2] = st_r.cfg.osc_code;
        cscs_pkg::ADDR_GPO:
          st_nxt.rdata[7:0] = {st_r.gpo_sel_remote, st_r.gpo_local};
        cscs_pkg::ADDR_STATUS:
          st_nxt.rdata[3:0] = {st_r.strap_ext, st_r.idle_high, st_r.on_osc, st_r.src == cscs_pkg::CSCS_SRC_PCLK};
        default:
          st_nxt.rdata = 32'h0;
      endcase
    end
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    // loss timer runs on the internal clock, reset by any pixel edge
    if (pclk_rise || pclk_fall)
      st_nxt.loss_cnt = '0;
    else if (st_r.loss_cnt != cscs_pkg::CNT_W'(cscs_pkg::LOSS_CYCLES))
      st_nxt.loss_cnt = st_r.loss_cnt + 1'b1;
    // source selection; settle stage keeps the switch clean
    case (st_r.src)
      cscs_pkg::CSCS_SRC_OSC:
      begin
        if (pclk_rise && !st_r.cfg.pclk_dis && power_down_n)
        begin
          st_nxt.src = cscs_pkg::CSCS_SRC_SETTLE;
          st_nxt.settle_cnt = '0;
        end
      end
      cscs_pkg::CSCS_SRC_SETTLE:
      begin
        if (st_r.loss_cnt == cscs_pkg::CNT_W'(cscs_pkg::LOSS_CYCLES) || st_r.cfg.pclk_dis)
          st_nxt.src = cscs_pkg::CSCS_SRC_OSC;
        else if (st_r.settle_cnt == cscs_pkg::CNT_W'(cscs_pkg::SETTLE_CYCLES - 1))
          st_nxt.src = cscs_pkg::CSCS_SRC_PCLK;
        else
          st_nxt.settle_cnt = st_r.settle_cnt + 1'b1;
      end
      cscs_pkg::CSCS_SRC_PCLK:
      begin
        if (st_r.loss_cnt == cscs_pkg::CNT_W'(cscs_pkg::LOSS_CYCLES) || st_r.cfg.pclk_dis)
          st_nxt.src = cscs_pkg::CSCS_SRC_OSC;
      end
      default:
        st_nxt.src = cscs_pkg::CSCS_SRC_OSC;
    endcase
    if (!power_down_n)
      st_nxt.src = cscs_pkg::CSCS_SRC_OSC;
    // pixel capture on the chosen edge
    // data delayed two stages, matching stage two of the edge detector, else the wrong word is latched
    cap_edge = st_r.cfg.edge_rise ? pclk_rise : pclk_fall;
    st_nxt.pix_dly = {st_r.pix_dly[0], pixel_in[cscs_pkg::PIX_W-1:0]};
    st_nxt.pix_ok = 1'b0;
    if (cap_edge)
    begin
      st_nxt.pix = st_r.pix_dly[1];
      st_nxt.pix_ok = 1'b1;
    end
    // frame emit: every 2nd pixel in 10-bit, 2 of every 3 in 12-bit
    st_nxt.frame_valid = 1'b0;
    if (st_r.src != cscs_pkg::CSCS_SRC_PCLK)
      st_nxt.phase = '0;
    else if (st_r.pix_ok)
    begin
      if (st_r.cfg.mode12)
      begin
        st_nxt.phase = (st_r.phase == 2'h2) ? 2'h0 : st_r.phase + 2'h1;
        st_nxt.frame_valid = st_r.phase != 2'h2;
      end
      else
      begin
        st_nxt.phase = {1'b0, ~st_r.phase[0]};
        st_nxt.frame_valid = st_r.phase[0];
      end
      st_nxt.frame_data = st_r.pix;
    end
    // oscillator source keeps link up with the default frame clock
    st_nxt.on_osc = power_down_n && st_r.src != cscs_pkg::CSCS_SRC_PCLK &&
      st_r.cfg.osc_code == cscs_pkg::OSC_CODE_DEFAULT;
    st_nxt.idle_high = !power_down_n || st_r.src == cscs_pkg::CSCS_SRC_SETTLE;
    if (!power_down_n)
      st_nxt.frame_valid = 1'b0;
    // halved oscillator reference, toggled per oscillator rising edge
    if (ext_mode && osc_rise)
      st_nxt.ref_div = ~st_r.ref_div;
    else if (!ext_mode)
      st_nxt.ref_div = 1'b0;
    // general outputs: local register or remote value per bit, except bits two and three in external mode
    for (int i = 0; i < 4; i++)
      st_nxt.gpo_out[i] = st_r.gpo_sel_remote[i] ? remote_gpio[i] : st_r.gpo_local[i];
    st_nxt.gpo_oe = 4'hF;
    if (ext_mode)
    begin
      st_nxt.gpo_out[2] = st_r.ref_div;
      st_nxt.gpo_out[3] = 1'b0;
      st_nxt.gpo_oe[3] = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.cfg.edge_rise <= cscs_pkg::CTRL_RESET[cscs_pkg::CTRL_EDGE_BIT];
      st_r.cfg.osc_code <= cscs_pkg::OSC_CODE_DEFAULT;
      st_r.src <= cscs_pkg::CSCS_SRC_OSC;
      st_r.idle_high <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign gpio_two_ref_out = st_r.ref_div;
  assign gpo_out = st_r.gpo_out;
  assign gpo_oe = st_r.gpo_oe;
  assign frame_data = st_r.frame_data;
  assign frame_valid = st_r.frame_valid;
  assign serial_idle_high = st_r.idle_high;
  assign link_on_osc = st_r.on_osc;
endmodule // cscs_clock_select

// ===== cscs_clock_select_assertions.sv
`timescale 1ns/10ps
module cscs_clock_select_assertions
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // imager side
  input wire logic power_down_n,
  input wire logic mode_strap_ext,
  input wire logic pclk_in,
  input wire logic gpio_three_osc_in,
  // outputs watched
  input wire logic gpio_two_ref_out,
  input wire logic [3:0] gpo_out,
  input wire logic [3:0] gpo_oe,
  input wire logic frame_valid,
  input wire logic serial_idle_high,
  input wire logic link_on_osc
);
  // cycles since the pixel clock last changed, saturating
  logic pclk_d_r;
  logic [7:0] quiet_r;
  always_ff @(posedge aclk)
  begin
    pclk_d_r <= pclk_in;
    if (!aresetn || pclk_in != pclk_d_r)
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF)
      quiet_r <= quiet_r + 8'h01;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // strap held for a few edges, so the sampled mode is settled
  sequence s_ext;
    mode_strap_ext [*4];
  endsequence
  sequence s_pclk_mode;
    !mode_strap_ext [*4];
  endsequence
  a_ref_halves: assert property (s_ext ##0 $rose(gpio_three_osc_in) |-> ##[1:4] $changed(gpio_two_ref_out))
    else $error("reference output missed an oscillator edge");
  a_ref_quiet: assert property (s_pclk_mode |-> !gpio_two_ref_out)
    else $error("reference output active outside external mode");
  a_gpo_three_input: assert property (s_ext |-> !gpo_oe[3] && !gpo_out[3])
    else $error("gpio three driven in external mode");
  a_all_gpo_on: assert property (s_pclk_mode |-> gpo_oe == 4'hF)
    else $error("not all outputs enabled in pixel clock mode");
  a_pd_idle_high: assert property (!power_down_n |=> serial_idle_high && !link_on_osc)
    else $error("serial outputs not idle high in power down");
  a_frame_pulse: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe longer than one cycle");
  a_osc_no_frames: assert property (link_on_osc || serial_idle_high |-> !frame_valid)
    else $error("frame sent while not on pixel clock");
  a_loss_fallback: assert property (quiet_r == 8'h46 && power_down_n && $past(power_down_n, 3) |-> !serial_idle_high)
    else $error("no fallback after pixel clock loss");
endmodule // cscs_clock_select_assertions

bind cscs_clock_select cscs_clock_select_assertions u_chk
(
  .aclk,
  .aresetn,
  .power_down_n,
  .mode_strap_ext,
  .pclk_in,
  .gpio_three_osc_in,
  .gpio_two_ref_out,
  .gpo_out,
  .gpo_oe,
  .frame_valid,
  .serial_idle_high,
  .link_on_osc
);

// ===== cscs_imager_model.sv
`timescale 1ns/10ps
module cscs_imager_model
#(
  parameter logic [13:0] PIX_RISE = 14'h2A5C,
  parameter logic [13:0] PIX_FALL = 14'h15A3
)
(
  // clock and controls
  input wire logic aclk,
  input wire logic run,
  input wire logic mode12,
  // imager outputs
  output logic pclk_in,
  output logic [13:0] pixel_in,
  output logic osc_out
);
  // pixel clock period 8 cycles; data stable around each edge
  logic [2:0] ph_r = 3'h0;
  logic [3:0] oc_r = 4'h0;
  initial pclk_in = 1'b0;
  initial pixel_in = 14'h0000;
  initial osc_out = 1'b0;
  always @(posedge aclk)
  begin
    oc_r <= (oc_r == (mode12 ? 4'hB : 4'hF)) ? 4'h0 : oc_r + 4'h1;
    osc_out <= oc_r < (mode12 ? 4'h6 : 4'h8);
    ph_r <= run ? ph_r + 3'h1 : ph_r;
    pclk_in <= run && ph_r < 3'h4;
    // stopped imager: clock stands low, data lines keep changing
    if (!run)
      pixel_in <= ~pixel_in;
    else
      pixel_in <= (ph_r >= 3'h6 || ph_r <= 3'h1) ? PIX_RISE : PIX_FALL;
  end
endmodule // cscs_imager_model

// ===== cscs_clock_select_bench.sv
`timescale 1ns/10ps
module cscs_clock_select_bench;
  localparam logic [13:0] PIX_A = 14'h2A5C;
  localparam logic [13:0] PIX_B = 14'h15A3;
  logic aclk = 1'b0, aresetn = 1'b0, power_down_n = 1'b1, mode_strap_ext = 1'b0, self_test = 1'b0;
  logic run = 1'b0, mode12 = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, remote_gpio = 4'hA;
  logic [1:0] remote_osc_code = 2'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, gpio_two_ref_out;
  logic frame_valid, serial_idle_high, link_on_osc, pclk_in, gpio_three_osc_in;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] gpo_out, gpo_oe;
  logic [13:0] frame_data, pixel_in;
  int mismatches = 0;
  int total_checks = 0;
  int fv;
  int tg;
  always #10 aclk = ~aclk;
  cscs_clock_select DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_down_n,
    .mode_strap_ext, .pclk_in, .pixel_in, .gpio_three_osc_in, .gpio_two_ref_out, .remote_gpio, .self_test,
    .remote_osc_code, .gpo_out, .gpo_oe, .frame_data, .frame_valid, .serial_idle_high, .link_on_osc);
  cscs_imager_model #(.PIX_RISE(PIX_A), .PIX_FALL(PIX_B)) u_img (.aclk, .run, .mode12, .pclk_in, .pixel_in,
    .osc_out(gpio_three_osc_in));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic ext);
    @(posedge aclk);
    aresetn <= 1'b0;
    mode_strap_ext <= ext;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // counts frame strobes and reference toggles, checks each frame's data
  task automatic watch(input int n, input logic [13:0] px);
    logic ref_d;
    fv = 0;
    tg = 0;
    ref_d = gpio_two_ref_out;
    repeat (n)
    begin
      @(posedge aclk);
      if (frame_valid === 1'b1)
      begin
        fv++;
        chk("frame_data", px, frame_data);
      end
      if (gpio_two_ref_out !== ref_d)
        tg++;
      ref_d = gpio_two_ref_out;
    end
  endtask
  task automatic t_regs;
    rchk(cscs_pkg::ADDR_CTRL, {29'h0, cscs_pkg::CTRL_RESET}, cscs_pkg::RESP_OKAY);
    rchk(cscs_pkg::ADDR_OSC, 32'h2, cscs_pkg::RESP_OKAY);
    rchk(8'h10, 32'h0, cscs_pkg::RESP_SLVERR);
    wchk(8'h10, 32'hF, cscs_pkg::RESP_SLVERR);
    repeat (70) @(posedge aclk);
    chk("link_on_osc", 1, link_on_osc);
    chk("idle_high", 0, serial_idle_high);
    rchk(cscs_pkg::ADDR_STATUS, 32'h2, cscs_pkg::RESP_OKAY);
    $display("test regs and oscillator done");
  endtask
  task automatic t_pclk;
    run <= 1'b1;
    repeat (100) @(posedge aclk);
    chk("link_on_osc", 0, link_on_osc);
    watch(160, PIX_A);
    chk("frames10", 10, fv);
    wchk(cscs_pkg::ADDR_CTRL, 32'h5, cscs_pkg::RESP_OKAY);
    mode12 <= 1'b1;
    repeat (50) @(posedge aclk);
    watch(192, PIX_A);
    chk("frames12", 16, fv);
    wchk(cscs_pkg::ADDR_CTRL, 32'h0, cscs_pkg::RESP_OKAY);
    mode12 <= 1'b0;
    repeat (50) @(posedge aclk);
    watch(160, PIX_B);
    chk("frames_fall", 10, fv);
    wchk(cscs_pkg::ADDR_CTRL, 32'h3, cscs_pkg::RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk("disabled_osc", 1, link_on_osc);
    wchk(cscs_pkg::ADDR_CTRL, 32'h1, cscs_pkg::RESP_OKAY);
    repeat (50) @(posedge aclk);
    chk("relock", 0, link_on_osc);
    $display("test pixel clock done");
  endtask
  task automatic t_loss_pd;
    run <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("loss_early", 0, link_on_osc);
    repeat (30) @(posedge aclk);
    chk("loss_late", 1, link_on_osc);
    power_down_n <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("pd_idle", 1, serial_idle_high);
    chk("pd_osc", 0, link_on_osc);
    power_down_n <= 1'b1;
    self_test <= 1'b1;
    remote_osc_code <= 2'h2;
    repeat (3) @(posedge aclk);
    wchk(cscs_pkg::ADDR_OSC, 32'h2, cscs_pkg::RESP_OKAY);
    rchk(cscs_pkg::ADDR_OSC, 32'h4, cscs_pkg::RESP_OKAY);
    chk("reserved_code", 0, link_on_osc);
    self_test <= 1'b0;
    repeat (2) @(posedge aclk);
    wchk(cscs_pkg::ADDR_OSC, 32'h2, cscs_pkg::RESP_OKAY);
    rchk(cscs_pkg::ADDR_OSC, 32'h2, cscs_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk("code01_osc", 1, link_on_osc);
    $display("test loss power down self test done");
  endtask
  task automatic t_gpo_ext;
    wchk(cscs_pkg::ADDR_GPO, 32'hF0, cscs_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("gpo_oe", 32'hF, gpo_oe);
    chk("gpo_remote", 32'hA, gpo_out);
    do_reset(1'b1);
    remote_gpio <= 4'hF;
    run <= 1'b1;
    wchk(cscs_pkg::ADDR_GPO, 32'hF0, cscs_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    watch(160, PIX_A);
    chk("ref_toggles", 10, tg);
    chk("gpio_three_osc_in_oe", 0, gpo_oe[3]);
    chk("gpio_three_osc_in_out", 0, gpo_out[3]);
    chk("gpo_low", 3, gpo_out[1:0]);
    rchk(cscs_pkg::ADDR_STATUS, 32'h9, cscs_pkg::RESP_OKAY);
    $display("test outputs and external mode done");
  endtask
  initial
  begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    do_reset(1'b0);
    t_regs();
    t_pclk();
    t_loss_pd();
    t_gpo_ext();
    complete_run();
  end
endmodule // cscs_clock_select_bench
